/* hdl/i2c_slave_serial_port.sv */
// two-wire slave serial port: address match, ack, stretch, flags
`timescale 1ns/1ps
module i2c_slave_serial_port
	import i2c_slave_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// bus pins, open drain, enables active low
	input wire logic bus_clock_pin_in,
	output logic bus_clock_pin_out,
	output logic bus_clock_pin_oe_n,
	input wire logic bus_data_pin_in,
	output logic bus_data_pin_out,
	output logic bus_data_pin_oe_n,
	// pin direction bits: [1] data, [0] clock, 1 = input
	input wire logic [1:0] portc_direction,
	// control register write
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	output logic [7:0] port_control_reg,
	// status
	output logic [7:0] port_status_reg,
	// own address register write
	input wire logic addr_wr,
	input wire logic [7:0] addr_wdata,
	output logic [7:0] own_address_reg,
	// received byte buffer
	input wire logic buf_rd,
	output logic [7:0] transfer_buffer,
	// transmit byte queue
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	// interrupt flag
	input wire logic irq_clr,
	output logic port_irq_flag
);
	// ==========================================
	// declarations
	logic [7:0] ctl_reg;
	logic [7:0] addr_reg;
	logic [7:0] buf_reg;
	logic [7:0] shift_register;
	logic irq_reg;
	logic bf_reg;
	logic ua_reg;
	logic rw_reg;
	logic data_reg;
	logic start_reg;
	logic stop_reg;
	logic ack_reg;
	logic xmit_reg;
	logic loaded_reg;
	logic tenbit_ok_reg;
	logic [3:0] cnt_reg;
	slave_state_t state_reg;
	addr_phase_t phase_reg;
	logic scl_s1, scl_s2, scl_s3;
	logic sda_s1, sda_s2, sda_s3;
	logic scl_rise, scl_fall, start_ev, stop_ev;
	logic en, mode_ok, slave_on, ten_mode, sp_irq;
	logic full, match_hi, match_lo, byte_done;
	logic fifo_valid, fifo_pop;
	logic [7:0] fifo_data;
	logic ov_set, ckr_clr, irq_set, bf_set, ua_set, rw_clr;
	logic scl_hold, sda_low;
	logic tx_end;

	// ==========================================
	// mode decode
	assign en = ctl_reg[CTL_EN];
	always_comb begin
		mode_ok = 1'b1;
		slave_on = 1'b1;
		ten_mode = 1'b0;
		sp_irq = 1'b0;
		case (ctl_reg[3:0])
			MODE_SLAVE7: begin
			end
			MODE_SLAVE10: ten_mode = 1'b1;
			MODE_SLAVE7_SP: sp_irq = 1'b1;
			MODE_SLAVE10_SP: begin
				ten_mode = 1'b1;
				sp_irq = 1'b1;
			end
			MODE_FW_MASTER: begin
				slave_on = 1'b0; // slave idle, events only
				sp_irq = 1'b1;
			end
			default: begin
				mode_ok = 1'b0;
				slave_on = 1'b0;
			end
		endcase
	end

	// ==========================================
	// pin synchronisers and edge detection
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_s3 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_s3 <= 1'b1;
		end else begin
			scl_s1 <= bus_clock_pin_in;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= bus_data_pin_in;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
		end
	end

	assign scl_rise = scl_s2 & ~scl_s3;
	assign scl_fall = ~scl_s2 & scl_s3;
	// data moving while clock stays high marks start or stop
	assign start_ev = en & mode_ok & scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
	assign stop_ev = en & mode_ok & scl_s2 & scl_s3 & sda_s2 & ~sda_s3;

	// ==========================================
	// byte decisions
	assign full = bf_reg | ctl_reg[CTL_OVF];
	assign match_hi = (shift_register[7:1] == addr_reg[7:1]);
	assign match_lo = (shift_register == addr_reg);
	assign byte_done = (state_reg == ST_RECV) & scl_fall & (cnt_reg == BIT_FULL);
	assign fifo_pop = (state_reg == ST_LOAD) & ~loaded_reg;

	// ==========================================
	// slave sequencer
	always_ff @(posedge clk) begin
		ov_set <= 1'b0;
		ckr_clr <= 1'b0;
		irq_set <= 1'b0;
		bf_set <= 1'b0;
		ua_set <= 1'b0;
		rw_clr <= 1'b0;
		tx_end <= 1'b0;
		if (!rst_n || !en || !slave_on) begin
			state_reg <= ST_IDLE;
			phase_reg <= PH_FIRST;
			cnt_reg <= BIT_ZERO;
			shift_register <= BYTE_ZERO;
			buf_reg <= BYTE_ZERO;
			ack_reg <= 1'b0;
			xmit_reg <= 1'b0;
			loaded_reg <= 1'b0;
			tenbit_ok_reg <= 1'b0;
			rw_reg <= 1'b0;
			data_reg <= 1'b0;
		end else if (stop_ev) begin
			state_reg <= ST_IDLE;
			tenbit_ok_reg <= 1'b0;
			rw_clr <= 1'b1;
			rw_reg <= 1'b0;
		end else if (start_ev) begin
			state_reg <= ST_RECV;
			phase_reg <= PH_FIRST;
			cnt_reg <= BIT_ZERO;
			ack_reg <= 1'b0;
			rw_clr <= 1'b1;
			rw_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_RECV: begin
					if (scl_rise && cnt_reg != BIT_FULL) begin
						// sample on rising clock edge
						shift_register <= {shift_register[6:0], sda_s2};
						cnt_reg <= cnt_reg + 1'b1;
					end else if (byte_done) begin
						state_reg <= ST_ACK;
						xmit_reg <= 1'b0;
						ack_reg <= 1'b0;
						case (phase_reg)
							PH_FIRST: begin
								if (match_hi && (!ten_mode ||
								    (shift_register[7:3] == TEN_HI_PATTERN &&
								     (!shift_register[0] || tenbit_ok_reg)))) begin
									ack_reg <= ~full;
									data_reg <= 1'b0;
									rw_reg <= shift_register[0];
									xmit_reg <= shift_register[0];
									if (!full) begin
										buf_reg <= shift_register;
										bf_set <= 1'b1;
									end else begin
										ov_set <= bf_reg;
									end
									if (ten_mode && !shift_register[0]) begin
										phase_reg <= PH_LOW;
										ua_set <= ~full;
									end else begin
										phase_reg <= PH_DATA;
									end
								end else begin
									state_reg <= ST_IDLE;
								end
							end
							PH_LOW: begin
								if (match_lo) begin
									ack_reg <= ~full;
									if (!full) begin
										buf_reg <= shift_register;
										bf_set <= 1'b1;
										ua_set <= 1'b1;
									end else begin
										ov_set <= bf_reg;
									end
									tenbit_ok_reg <= 1'b1;
									phase_reg <= PH_DATA;
								end else begin
									state_reg <= ST_IDLE;
								end
							end
							default: begin
								data_reg <= 1'b1;
								ack_reg <= ~full;
								if (!full) begin
									buf_reg <= shift_register;
									bf_set <= 1'b1;
								end else begin
									ov_set <= 1'b1;
								end
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						// ninth falling edge ends the ack bit
						ack_reg <= 1'b0;
						irq_set <= 1'b1;
						cnt_reg <= BIT_ZERO;
						if (xmit_reg && ack_reg) begin
							state_reg <= ST_LOAD;
							loaded_reg <= 1'b0;
							ckr_clr <= 1'b1;
						end else if (ack_reg ||
						    (phase_reg == PH_DATA && !xmit_reg)) begin
							// acked byte or refused write byte: stay addressed, next byte irqs
							state_reg <= ST_RECV;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_LOAD: begin
					if (fifo_pop && fifo_valid) begin
						shift_register <= fifo_data;
						buf_reg <= fifo_data;
						bf_set <= 1'b1;
						loaded_reg <= 1'b1;
					end else if (loaded_reg && ctl_reg[CTL_CKR]) begin
						state_reg <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (scl_fall) begin
						// next bit appears while clock is low
						shift_register <= {shift_register[6:0], 1'b1};
						cnt_reg <= cnt_reg + 1'b1;
						if (cnt_reg == BIT_LAST_TX) begin
							state_reg <= ST_MACK;
						end
					end
				end
				ST_MACK: begin
					// count is full on entry; zero marks an ack seen
					if (scl_rise && cnt_reg == BIT_FULL) begin
						if (sda_s2) begin
							// not acknowledged: slave logic resets
							state_reg <= ST_IDLE;
							rw_clr <= 1'b1;
							rw_reg <= 1'b0;
							tx_end <= 1'b1;
							data_reg <= 1'b0;
						end else begin
							cnt_reg <= BIT_ZERO;
						end
					end else if (scl_fall && cnt_reg == BIT_ZERO) begin
						irq_set <= 1'b1;
						rw_clr <= 1'b1;
						rw_reg <= 1'b0;
						loaded_reg <= 1'b0;
						ckr_clr <= 1'b1;
						state_reg <= ST_LOAD;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// control register: software writes, hardware sets win
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctl_reg <= CTL_RESET;
		end else begin
			if (ctrl_wr) begin
				ctl_reg <= ctrl_wdata;
			end else if (ckr_clr) begin
				ctl_reg[CTL_CKR] <= 1'b0;
			end
			if (ov_set) begin
				ctl_reg[CTL_OVF] <= 1'b1;
			end
			if (tx_valid && !tx_ready) begin
				ctl_reg[CTL_WCOL] <= 1'b1;
			end
		end
	end

	// ==========================================
	// own address register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			addr_reg <= BYTE_ZERO;
		end else if (addr_wr) begin
			addr_reg <= addr_wdata;
		end
	end

	// ==========================================
	// buffer full and update address flags
	always_ff @(posedge clk) begin
		if (!rst_n || !en) begin
			bf_reg <= 1'b0;
			ua_reg <= 1'b0;
		end else begin
			if (bf_set) begin
				bf_reg <= 1'b1;
			end else if (buf_rd || tx_end) begin
				bf_reg <= 1'b0;
			end
			if (ua_set) begin
				ua_reg <= 1'b1;
			end else if (addr_wr) begin
				ua_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// start/stop status and interrupt flag
	always_ff @(posedge clk) begin
		if (!rst_n || !en) begin
			start_reg <= 1'b0;
			stop_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			if (start_ev) begin
				start_reg <= 1'b1;
				stop_reg <= 1'b0;
			end else if (stop_ev) begin
				start_reg <= 1'b0;
				stop_reg <= 1'b1;
			end
			// set wins over a clear in the same cycle
			if (irq_set || (sp_irq && (start_ev || stop_ev))) begin
				irq_reg <= 1'b1;
			end else if (irq_clr) begin
				irq_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// transmit queue
	tx_byte_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(TX_FIFO_DEPTH)
	) u_tx_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.flush(~en),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// ==========================================
	// open-drain pin control
	// stretch covers both the reload wait and the 10-bit address update
	// update-address stretch waits until the ack bit has clocked out
	assign scl_hold = (state_reg == ST_LOAD) |
		ua_reg & (state_reg != ST_ACK);
	assign sda_low = ack_reg & (state_reg == ST_ACK) |
		(state_reg == ST_SEND) & ~shift_register[7];
	assign bus_clock_pin_out = 1'b0;
	assign bus_data_pin_out = 1'b0;
	assign bus_clock_pin_oe_n = ~(en & slave_on & portc_direction[0] & scl_hold);
	assign bus_data_pin_oe_n = ~(en & slave_on & portc_direction[1] & sda_low);

	// ==========================================
	// register views
	assign port_control_reg = ctl_reg;
	assign own_address_reg = addr_reg;
	assign transfer_buffer = buf_reg;
	assign port_irq_flag = irq_reg;
	assign port_status_reg = {2'b00, data_reg, stop_reg, start_reg,
		rw_reg & ~rw_clr, ua_reg, bf_reg};

endmodule : i2c_slave_serial_port

/* hdl/i2c_slave_pkg.sv */
// shared constants for the two-wire slave serial port
package i2c_slave_pkg;

	// ==========================================
	// mode select field codes
	localparam logic [3:0] MODE_SLAVE7 = 4'h6;
	localparam logic [3:0] MODE_SLAVE10 = 4'h7;
	localparam logic [3:0] MODE_FW_MASTER = 4'hB;
	localparam logic [3:0] MODE_SLAVE7_SP = 4'hE;
	localparam logic [3:0] MODE_SLAVE10_SP = 4'hF;

	// ==========================================
	// port_control_reg field positions
	localparam int CTL_WCOL = 7;
	localparam int CTL_OVF = 6;
	localparam int CTL_EN = 5;
	localparam int CTL_CKR = 4;
	localparam logic [7:0] CTL_RESET = 8'h00;

	// ==========================================
	// port_status_reg field positions
	localparam int STA_DATA = 5;
	localparam int STA_STOP = 4;
	localparam int STA_START = 3;
	localparam int STA_RW = 2;
	localparam int STA_UA = 1;
	localparam int STA_BF = 0;

	// ==========================================
	// byte framing
	localparam logic [3:0] BIT_LAST_TX = 4'h7;
	localparam logic [3:0] BIT_FULL = 4'h8;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [4:0] TEN_HI_PATTERN = 5'h1E;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam int TX_FIFO_DEPTH = 8;
	localparam int BYTE_W = 8;

	// ==========================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RECV = 3'b001,
		ST_ACK = 3'b010,
		ST_LOAD = 3'b011,
		ST_SEND = 3'b100,
		ST_MACK = 3'b101
	} slave_state_t;

	typedef enum logic [1:0] {
		PH_FIRST = 2'b00,
		PH_LOW = 2'b01,
		PH_DATA = 2'b10
	} addr_phase_t;

endpackage : i2c_slave_pkg

/* hdl/tx_byte_fifo.sv */
// small synchronous fifo holding bytes queued for transmission
`timescale 1ns/1ps
module tx_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// ==========================================
	// storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// ==========================================
	// pointers and fill level
	always_ff @(posedge clk) begin
		if (!rst_n || flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule : tx_byte_fifo

/* bench/port_checker.sv */
// assertions on the slave serial port pins and software flags
`timescale 1ns/1ps
module port_checker
	import i2c_slave_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// bus side
	input wire logic bus_clock_pin_in,
	input wire logic bus_clock_pin_out,
	input wire logic bus_clock_pin_oe_n,
	input wire logic bus_data_pin_out,
	input wire logic bus_data_pin_oe_n,
	input wire logic [1:0] portc_direction,
	// software side
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic [7:0] port_control_reg,
	input wire logic [7:0] port_status_reg,
	input wire logic addr_wr,
	input wire logic [7:0] addr_wdata,
	input wire logic [7:0] own_address_reg,
	input wire logic buf_rd,
	input wire logic irq_clr,
	input wire logic port_irq_flag
);
	logic slave_on;
	assign slave_on = port_control_reg[CTL_EN] && (port_control_reg[3:0]
		inside {MODE_SLAVE7, MODE_SLAVE10, MODE_SLAVE7_SP, MODE_SLAVE10_SP});
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// ======
	// named steps
	sequence s_port_off;
		!slave_on ##1 !slave_on;
	endsequence
	// synchroniser has caught up with a high clock line
	sequence s_clock_high;
		bus_clock_pin_in [*4];
	endsequence
	// ======
	// properties
	property p_low_only;
		!bus_clock_pin_out && !bus_data_pin_out;
	endproperty
	a_low_only: assert property (p_low_only)
		else $error("line driven high");
	property p_idle_off;
		s_port_off |-> bus_clock_pin_oe_n && bus_data_pin_oe_n;
	endproperty
	a_idle_off: assert property (p_idle_off)
		else $error("pulls while inactive");
	property p_dir_gate;
		!portc_direction[1] [*2] |-> bus_data_pin_oe_n;
	endproperty
	a_dir_gate: assert property (p_dir_gate)
		else $error("data pulled while output");
	property p_data_steady;
		s_clock_high |-> $stable(bus_data_pin_oe_n);
	endproperty
	a_data_steady: assert property (p_data_steady)
		else $error("data moved in clock high");
	property p_ctrl_wr;
		ctrl_wr |=> port_control_reg[3:0] == $past(ctrl_wdata[3:0])
			&& port_control_reg[CTL_EN] == $past(ctrl_wdata[CTL_EN]);
	endproperty
	a_ctrl_wr: assert property (p_ctrl_wr)
		else $error("control write lost");
	property p_addr_wr;
		addr_wr |=> own_address_reg == $past(addr_wdata);
	endproperty
	a_addr_wr: assert property (p_addr_wr)
		else $error("address write lost");
	property p_irq_hold;
		port_irq_flag && !irq_clr && !ctrl_wr |=> port_irq_flag;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("irq flag dropped");
	property p_buf_rd;
		buf_rd && !port_status_reg[STA_RW] && bus_data_pin_oe_n
			|=> !port_status_reg[STA_BF];
	endproperty
	a_buf_rd: assert property (p_buf_rd)
		else $error("buffer read kept full flag");
endmodule : port_checker

/* bench/i2c_master_model.sv */
// behavioural two-wire bus master, 400 ns bit time
`timescale 1ns/1ps
module i2c_master_model (
	// wired line levels
	input wire logic scl,
	input wire logic sda,
	// open-drain drives, 1 = released; stretch wait ran out
	output logic scl_rel,
	output logic sda_rel,
	output logic stuck
);
	initial begin
		scl_rel = 1'b1;
		sda_rel = 1'b1;
		stuck = 1'b0;
	end
	// ======
	// one pulse; bounded wait so a stuck stretch cannot hang the run
	task pulse(output logic v);
		int n;
		n = 0;
		#150;
		scl_rel = 1'b1;
		while (!scl && n < 4000) begin
			#50;
			n++;
		end
		stuck = stuck | (n == 4000);
		#100;
		v = sda;
		#100;
		scl_rel = 1'b0;
		#50;
	endtask : pulse
	task start();
		sda_rel = 1'b1;
		scl_rel = 1'b1;
		#200;
		sda_rel = 1'b0;
		#200;
		scl_rel = 1'b0;
		#50;
	endtask : start
	task stop();
		sda_rel = 1'b0;
		#150;
		scl_rel = 1'b1;
		#200;
		sda_rel = 1'b1;
		#200;
	endtask : stop
	// ======
	// bytes go msb first, then the acknowledge bit
	task send(input logic [7:0] b, output logic ack);
		logic v;
		for (int i = 7; i >= 0; i--) begin
			sda_rel = b[i];
			pulse(v);
		end
		sda_rel = 1'b1;
		pulse(v);
		ack = !v;
		#400;
	endtask : send
	task recv(output logic [7:0] b, input logic nack);
		logic v;
		for (int i = 7; i >= 0; i--) begin
			pulse(v);
			b[i] = v;
		end
		sda_rel = nack;
		pulse(v);
		sda_rel = 1'b1;
		#400;
	endtask : recv
endmodule : i2c_master_model

/* bench/tb.sv */
// self-checking bench for the two-wire slave serial port
`timescale 1ns/1ps
module tb;
	import i2c_slave_pkg::*;
	// ======
	// inputs, wiring, bookkeeping
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] portc_direction = 2'b11;
	logic ctrl_wr, addr_wr, buf_rd, irq_clr, tx_valid;
	logic [7:0] ctrl_wdata, addr_wdata, tx_data, d, b, hi, lo;
	wire logic scl_rel, sda_rel, stuck, tx_ready, port_irq_flag;
	wire logic bus_clock_pin_out, bus_clock_pin_oe_n;
	wire logic bus_data_pin_out, bus_data_pin_oe_n;
	wire logic [7:0] port_control_reg, port_status_reg;
	wire logic [7:0] own_address_reg, transfer_buffer;
	// pulled-up lines
	wire logic scl = scl_rel & (bus_clock_pin_oe_n | bus_clock_pin_out);
	wire logic sda = sda_rel & (bus_data_pin_oe_n | bus_data_pin_out);
	int error_cnt = 0;
	int compares = 0;
	logic [6:0] own;
	logic ack;
	logic [7:0] txq [8];
	logic [3:0] modes [5] = '{MODE_SLAVE10, MODE_FW_MASTER,
		MODE_SLAVE7_SP, MODE_SLAVE10_SP, MODE_SLAVE7};

	always #25 clk = ~clk;

	i2c_slave_serial_port i_dut (
		.clk(clk), .rst_n(rst_n), .bus_clock_pin_in(scl),
		.bus_clock_pin_out(bus_clock_pin_out),
		.bus_clock_pin_oe_n(bus_clock_pin_oe_n), .bus_data_pin_in(sda),
		.bus_data_pin_out(bus_data_pin_out),
		.bus_data_pin_oe_n(bus_data_pin_oe_n),
		.portc_direction(portc_direction), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .port_control_reg(port_control_reg),
		.port_status_reg(port_status_reg), .addr_wr(addr_wr),
		.addr_wdata(addr_wdata), .own_address_reg(own_address_reg),
		.buf_rd(buf_rd), .transfer_buffer(transfer_buffer),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.irq_clr(irq_clr), .port_irq_flag(port_irq_flag));
	i2c_master_model i_mst (.scl(scl), .sda(sda), .scl_rel(scl_rel),
		.sda_rel(sda_rel), .stuck(stuck));

	// ======
	// expectations and helpers
	function automatic logic [7:0] addr_byte(input logic [6:0] a,
		input logic rw);
		return {a, rw};
	endfunction : addr_byte
	function automatic logic [7:0] ctl_val(input logic [3:0] m);
		return {4'h3, m};
	endfunction : ctl_val
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk
	// s = {irq_clr, buf_rd, addr_wr, ctrl_wr}
	task sw(input logic [3:0] s, input logic [7:0] v);
		@(posedge clk);
		{irq_clr, buf_rd, addr_wr, ctrl_wr} <= s;
		ctrl_wdata <= v;
		addr_wdata <= v;
		@(posedge clk);
		{irq_clr, buf_rd, addr_wr, ctrl_wr} <= 4'h0;
		@(posedge clk);
		#1;
	endtask : sw
	task wr(input logic [7:0] v, input logic ok, input logic [7:0] be);
		i_mst.send(v, ack);
		chk("ack", 8'(ok), 8'(ack));
		chk("buffer", be, transfer_buffer);
		chk("irq", 8'h01, 8'(port_irq_flag));
	endtask : wr
	task finish_test();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	initial begin
		#3000000;
		error_cnt++;
		finish_test();
	end

	// ======
	// tests
	initial begin
		{ctrl_wr, addr_wr, buf_rd, irq_clr, tx_valid} = 5'h00;
		{ctrl_wdata, addr_wdata, tx_data} = 24'h000000;
		void'($urandom(32'h97EA));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk("control", 8'h00, port_control_reg);
		chk("status", 8'h00, port_status_reg);
		chk("oe_n", 8'h03, 8'({bus_clock_pin_oe_n, bus_data_pin_oe_n}));
		own = 7'($urandom);
		sw(4'h2, addr_byte(own, 1'b0));
		chk("own address", addr_byte(own, 1'b0), own_address_reg);
		foreach (modes[i]) begin
			sw(4'h1, ctl_val(modes[i]));
			chk("control", ctl_val(modes[i]), port_control_reg);
		end
		$display("test setup done");
		i_mst.start();
		wr(addr_byte(own, 1'b0), 1'b1, addr_byte(own, 1'b0));
		chk("rw bf", 8'h01, 8'(port_status_reg[STA_RW:STA_BF]));
		for (int k = 0; k < 4; k++) begin
			sw(4'hC, 8'h00);
			chk("bf irq", 8'h00, 8'({port_status_reg[STA_BF], port_irq_flag}));
			d = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
			wr(d, 1'b1, d);
		end
		sw(4'h8, 8'h00);
		wr(~d, 1'b0, d);
		chk("overflow", 8'h01, 8'(port_control_reg[CTL_OVF]));
		sw(4'hC, 8'h00);
		wr(8'($urandom), 1'b0, d);
		i_mst.stop();
		sw(4'hD, ctl_val(MODE_SLAVE7));
		chk("overflow", 8'h00, 8'(port_control_reg[CTL_OVF]));
		$display("test receive done");
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			portc_direction <= (k == 1) ? 2'b01 : 2'b11;
			sw(4'h1, (k == 2) ? 8'h16 : ctl_val(MODE_SLAVE7));
			i_mst.start();
			i_mst.send(addr_byte(own ^ 7'(k == 0), 1'b0), ack);
			chk("refused ack", 8'h00, 8'(ack));
			if (k != 1)
				chk("irq", 8'h00, 8'(port_irq_flag));
			i_mst.stop();
			@(posedge clk);
			portc_direction <= 2'b11;
			sw(4'hD, ctl_val(MODE_SLAVE7));
		end
		$display("test refusal done");
		for (int i = 0; i < 9; i++) begin
			if (i < 8)
				txq[i] = 8'($urandom);
			chk("queue ready", 8'(i < 8), 8'(tx_ready));
			@(posedge clk);
			tx_valid <= 1'b1;
			tx_data <= txq[i % 8];
			@(posedge clk);
			tx_valid <= 1'b0;
			#1;
		end
		repeat (2) @(posedge clk);
		#1;
		chk("collision", 8'h01, 8'(port_control_reg[CTL_WCOL]));
		sw(4'h1, ctl_val(MODE_SLAVE7));
		i_mst.start();
		i_mst.send(addr_byte(own, 1'b1), ack);
		chk("read ack", 8'h01, 8'(ack));
		for (int i = 0; i < 2; i++) begin
			chk("rw oe irq", (i == 0) ? 8'h05 : 8'h01, 8'({port_status_reg[STA_RW], bus_clock_pin_oe_n, port_irq_flag}));
			fork
				sw(4'h9, ctl_val(MODE_SLAVE7));
				i_mst.recv(b, 1'(i));
			join
			chk("read data", txq[i], b);
		end
		chk("rw after nack", 8'h01, 8'({port_status_reg[STA_RW], bus_data_pin_oe_n}));
		i_mst.stop();
		chk("master wait", 8'h00, 8'(stuck));
		$display("test transmit done");
		hi = {TEN_HI_PATTERN, 2'($urandom), 1'b0};
		lo = 8'($urandom);
		sw(4'hD, ctl_val(MODE_SLAVE10_SP));
		sw(4'h2, hi);
		i_mst.start();
		chk("start irq", 8'h01, 8'(port_irq_flag));
		sw(4'h8, 8'h00);
		wr(hi, 1'b1, hi);
		chk("ua hold", 8'h02,
			8'({port_status_reg[STA_UA], bus_clock_pin_oe_n}));
		sw(4'hE, lo);
		chk("ua hold", 8'h01,
			8'({port_status_reg[STA_UA], bus_clock_pin_oe_n}));
		wr(lo, 1'b1, lo);
		chk("ua hold", 8'h02,
			8'({port_status_reg[STA_UA], bus_clock_pin_oe_n}));
		sw(4'hE, hi);
		d = 8'($urandom);
		wr(d, 1'b1, d);
		sw(4'hC, 8'h00);
		i_mst.stop();
		chk("stop irq", 8'h03,
			8'({port_status_reg[STA_STOP], port_irq_flag}));
		chk("master wait", 8'h00, 8'(stuck));
		$display("test ten-bit done");
		finish_test();
	end
endmodule : tb

bind i2c_slave_serial_port port_checker i_chk (
	.clk(clk), .rst_n(rst_n), .bus_clock_pin_in(bus_clock_pin_in),
	.bus_clock_pin_out(bus_clock_pin_out),
	.bus_clock_pin_oe_n(bus_clock_pin_oe_n),
	.bus_data_pin_out(bus_data_pin_out),
	.bus_data_pin_oe_n(bus_data_pin_oe_n),
	.portc_direction(portc_direction), .ctrl_wr(ctrl_wr),
	.ctrl_wdata(ctrl_wdata), .port_control_reg(port_control_reg),
	.port_status_reg(port_status_reg), .addr_wr(addr_wr),
	.addr_wdata(addr_wdata), .own_address_reg(own_address_reg),
	.buf_rd(buf_rd), .irq_clr(irq_clr), .port_irq_flag(port_irq_flag));
